// File: design/cts_pkg.sv
// Constants, register map and field layouts of the CT supervision block.
// Assumes one 250 MHz clock and an APB master with 32-bit data.
// Notes on behaviour
// - Alarm allowed only while no phase magnitude exceeds the high limit.
// - Alarm needs at least one phase magnitude above the low limit.
// - Alarm needs at least one phase magnitude below the low limit.
// - Ratio of smallest to largest phase magnitude must be below ratio setting.
// - Negative over positive sequence ratio must exceed the sequence setting.
// - Optional: absolute sum of phases and residual must exceed sum limit.
// - All enabled conditions must hold in the same cycle.
// - Alarm asserts only after the condition held for the alarm delay; the delay counts whole ms ticks, so up to 1 ms early.
// - Eight parameter groups, active one picked by one group-select input.
// - Block input and group change act at once; group change keeps the alarm delay, block input restarts it.
// - Two outputs: alarm and blocked.
// - Every on and off edge of each output emits a millisecond stamped event.
// - Cumulative alarm and blocked event counters, clearable by software.
// - Residual monitoring can be switched on or off on its own.
// - Samples and magnitudes are evaluated on every clock cycle.
// - Current comparisons release at 97 and 103 percent of the threshold.
// - Residual source selector: unused, first input or second input.
// - Residual channel added or subtracted per polarity bit, add by default.

package cts_pkg;

	// ******************************
	// Widths
	// ******************************
	localparam int ADDR_W = 9;
	localparam int DATA_W = 32;
	localparam int CUR_W  = 16;
	localparam int SMP_W  = 16;
	localparam int FLD_W  = 16;
	localparam int TS_W   = 32;
	localparam int CNT_W  = 32;
	localparam int NGRP   = 8;
	localparam int NFLD   = 6;

	// ******************************
	// Register map
	// ******************************
	localparam logic [ADDR_W-1:0] A_CTRL    = 9'h000;
	localparam logic [ADDR_W-1:0] A_STATUS  = 9'h004;
	localparam logic [ADDR_W-1:0] A_ALM_CNT = 9'h008;
	localparam logic [ADDR_W-1:0] A_BLK_CNT = 9'h00c;
	localparam logic [ADDR_W-1:0] A_CNT_CLR = 9'h010;
	localparam logic [ADDR_W-1:0] A_TIME    = 9'h014;
	// Group window: addr[8] set, group in addr[7:5], field in addr[4:2]
	localparam int GRP_BIT = 8;
	localparam int GRP_LSB = 5;
	localparam int FLD_LSB = 2;

	localparam logic [2:0] F_HI    = 3'h0;
	localparam logic [2:0] F_LO    = 3'h1;
	localparam logic [2:0] F_RATIO = 3'h2;
	localparam logic [2:0] F_SEQ   = 3'h3;
	localparam logic [2:0] F_SUM   = 3'h4;
	localparam logic [2:0] F_DLY   = 3'h5;

	// CTRL and STATUS bits
	localparam int C_RSEL = 0;
	localparam int C_RSUB = 2;
	localparam int C_SUM  = 3;
	localparam int C_RMON = 4;
	localparam int S_ALM  = 0;
	localparam int S_BLK  = 1;
	localparam int S_COND = 2;
	localparam int S_GRP  = 3;
	localparam int CLR_ALM = 0;
	localparam int CLR_BLK = 1;

	typedef enum logic [1:0] {
		RSEL_NONE = 2'h0,
		RSEL_ONE  = 2'h1,
		RSEL_TWO  = 2'h2
	} cts_rsel_e;

	// ******************************
	// Reset values (currents in 0.01 x nominal)
	// ******************************
	localparam logic [FLD_W-1:0] D_HI    = 16'h0078;
	localparam logic [FLD_W-1:0] D_LO    = 16'h000a;
	localparam logic [FLD_W-1:0] D_RATIO = 16'h0032;
	localparam logic [FLD_W-1:0] D_SEQ   = 16'h0032;
	localparam logic [FLD_W-1:0] D_SUM   = 16'h0064;
	localparam logic [FLD_W-1:0] D_DLY   = 16'h0014;

	// ******************************
	// Hysteresis and timing
	// ******************************
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam logic [6:0] PCT_LOW  = 7'h61;
	localparam logic [6:0] PCT_HIGH = 7'h67;
	localparam int CLK_NS   = 4;
	localparam int TICK_NS  = 1000000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;

endpackage : cts_pkg

// File: design/cts_hyst_cmp.sv
// Threshold comparator with fixed release points.
// Assumes mag and thr on the block clock, unsigned, same scale.
`timescale 1ns/1ps

module cts_hyst_cmp
	import cts_pkg::*;
#(
	parameter int W = 16
)(
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] mag,
	input  wire logic [W-1:0] thr,
	input  wire logic         under,
	output logic              hit_ff
);

	localparam int PW = W + 7;

	logic [PW-1:0] mag_scl;
	logic [PW-1:0] thr_lo;
	logic [PW-1:0] thr_hi;
	logic          set_c;
	logic          rel_c;

	// Scaling by 100 keeps 97 and 103 percent exact, no divider
	assign mag_scl = PW'(mag) * PW'(PCT_FULL);
	assign thr_lo  = PW'(thr) * PW'(PCT_LOW);
	assign thr_hi  = PW'(thr) * PW'(PCT_HIGH);
	assign set_c   = under ? (mag < thr) : (mag > thr);
	assign rel_c   = under ? (mag_scl > thr_hi) : (mag_scl < thr_lo);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			hit_ff <= 1'b0;
		else if (hit_ff && rel_c)
			hit_ff <= 1'b0;
		else if (!hit_ff && set_c)
			hit_ff <= 1'b1;
	end

endmodule // cts_hyst_cmp

// File: design/cts_supervision.sv
// CT supervision: condition logic, alarm timing, events, counters, APB regs.
// Assumes measurement inputs and block/group inputs come from logic on clk.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps

module cts_supervision
	import cts_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
)(
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic [ADDR_W-1:0]        paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [DATA_W-1:0]        pwdata,
	output logic      [DATA_W-1:0]        prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic [CUR_W-1:0]         phase_a_current,
	input  wire logic [CUR_W-1:0]         phase_b_current,
	input  wire logic [CUR_W-1:0]         phase_c_current,
	input  wire logic signed [SMP_W-1:0]  phase_a_sample,
	input  wire logic signed [SMP_W-1:0]  phase_b_sample,
	input  wire logic signed [SMP_W-1:0]  phase_c_sample,
	input  wire logic signed [SMP_W-1:0]  residual_input_one,
	input  wire logic signed [SMP_W-1:0]  residual_input_two,
	input  wire logic [CUR_W-1:0]         pos_seq_current,
	input  wire logic [CUR_W-1:0]         neg_seq_current,
	input  wire logic                     block_in,
	input  wire logic [2:0]               grp_sel,
	output logic                          alarm_out,
	output logic                          blocked_out,
	output logic                          evt_valid,
	output logic      [3:0]               evt_flags,
	output logic      [TS_W-1:0]          evt_time_ms
);

	localparam int SUM_W = SMP_W + 2;
	localparam int RW    = CUR_W + FLD_W;

	// ******************************
	// Functions
	// ******************************
	function automatic logic [CUR_W-1:0] f_max3(input logic [CUR_W-1:0] a,
		input logic [CUR_W-1:0] b, input logic [CUR_W-1:0] c);
		logic [CUR_W-1:0] m;
		m = (a > b) ? a : b;
		return (m > c) ? m : c;
	endfunction

	function automatic logic [CUR_W-1:0] f_min3(input logic [CUR_W-1:0] a,
		input logic [CUR_W-1:0] b, input logic [CUR_W-1:0] c);
		logic [CUR_W-1:0] m;
		m = (a < b) ? a : b;
		return (m < c) ? m : c;
	endfunction

	function automatic logic [FLD_W-1:0] f_par_rst(input logic [2:0] f);
		logic [FLD_W-1:0] v;
		v = D_DLY;
		unique case (f)
			F_HI:    v = D_HI;
			F_LO:    v = D_LO;
			F_RATIO: v = D_RATIO;
			F_SEQ:   v = D_SEQ;
			F_SUM:   v = D_SUM;
			default: v = D_DLY;
		endcase
		return v;
	endfunction

	// ******************************
	// Registers
	// ******************************
	logic [FLD_W-1:0]  par_ff [NGRP][NFLD];
	logic [1:0]        rsel_ff;
	logic              rsub_ff;
	logic              sum_en_ff;
	logic              rmon_ff;
	logic [CNT_W-1:0]  alm_cnt_ff;
	logic [CNT_W-1:0]  blk_cnt_ff;
	logic [31:0]       tick_cnt_ff;
	logic [TS_W-1:0]   time_ms_ff;
	logic [FLD_W-1:0]  dly_cnt_ff;
	logic              alarm_ff;
	logic              blocked_ff;
	logic              evt_valid_ff;
	logic [3:0]        evt_flags_ff;
	logic [TS_W-1:0]   evt_time_ff;
	logic [DATA_W-1:0] prdata_ff;
	logic              pslverr_ff;

	// ******************************
	// Bus decode
	// ******************************
	logic             setup;
	logic             wr_acc;
	logic             grp_hit;
	logic [2:0]       a_grp;
	logic [2:0]       a_fld;
	logic             gen_hit;
	logic             clr_alm;
	logic             clr_blk;

	assign setup   = psel && !penable;
	assign wr_acc  = psel && penable && pwrite && !pslverr_ff;
	assign a_grp   = paddr[GRP_LSB +: 3];
	assign a_fld   = paddr[FLD_LSB +: 3];
	assign grp_hit = paddr[GRP_BIT] && (a_fld < 3'(NFLD)) && (paddr[1:0] == 2'h0);
	assign gen_hit = (paddr == A_CTRL) || (paddr == A_STATUS) || (paddr == A_ALM_CNT)
		|| (paddr == A_BLK_CNT) || (paddr == A_CNT_CLR) || (paddr == A_TIME);
	assign clr_alm = wr_acc && (paddr == A_CNT_CLR) && pwdata[CLR_ALM];
	assign clr_blk = wr_acc && (paddr == A_CNT_CLR) && pwdata[CLR_BLK];

	// ******************************
	// Active parameter set
	// ******************************
	logic [FLD_W-1:0] hi_lim;
	logic [FLD_W-1:0] lo_lim;
	logic [FLD_W-1:0] ph_ratio;
	logic [FLD_W-1:0] sq_ratio;
	logic [FLD_W-1:0] sum_lim;
	logic [FLD_W-1:0] dly_ms;

	// Group change takes effect on the next compare, no restart
	assign hi_lim   = par_ff[grp_sel][F_HI];
	assign lo_lim   = par_ff[grp_sel][F_LO];
	assign ph_ratio = par_ff[grp_sel][F_RATIO];
	assign sq_ratio = par_ff[grp_sel][F_SEQ];
	assign sum_lim  = par_ff[grp_sel][F_SUM];
	assign dly_ms   = par_ff[grp_sel][F_DLY];

	// ******************************
	// Threshold comparators
	// ******************************
	logic [CUR_W-1:0] ph_mag [3];
	logic [2:0]       over_hi;
	logic [2:0]       over_lo;
	logic [2:0]       under_lo;

	assign ph_mag[0] = phase_a_current;
	assign ph_mag[1] = phase_b_current;
	assign ph_mag[2] = phase_c_current;

	for (genvar i = 0; i < 3; i++)
	begin : g_ph
		cts_hyst_cmp #(.W(CUR_W)) u_hi (
			.clk    (clk),
			.nrst   (nrst),
			.mag    (ph_mag[i]),
			.thr    (hi_lim),
			.under  (1'b0),
			.hit_ff (over_hi[i])
		);
		cts_hyst_cmp #(.W(CUR_W)) u_lo (
			.clk    (clk),
			.nrst   (nrst),
			.mag    (ph_mag[i]),
			.thr    (lo_lim),
			.under  (1'b0),
			.hit_ff (over_lo[i])
		);
		cts_hyst_cmp #(.W(CUR_W)) u_ul (
			.clk    (clk),
			.nrst   (nrst),
			.mag    (ph_mag[i]),
			.thr    (lo_lim),
			.under  (1'b1),
			.hit_ff (under_lo[i])
		);
	end

	// ******************************
	// Ratio checks
	// ******************************
	logic [CUR_W-1:0] ph_min;
	logic [CUR_W-1:0] ph_max;
	logic [RW-1:0]    min_scl;
	logic [RW-1:0]    max_scl;
	logic [RW-1:0]    neg_scl;
	logic [RW-1:0]    pos_scl;
	logic             ratio_ok;
	logic             seq_ok;

	// Ratios in percent; cross-multiplied to avoid a divider
	assign ph_min   = f_min3(phase_a_current, phase_b_current, phase_c_current);
	assign ph_max   = f_max3(phase_a_current, phase_b_current, phase_c_current);
	assign min_scl  = RW'(ph_min) * RW'(PCT_FULL);
	assign max_scl  = RW'(ph_max) * RW'(ph_ratio);
	assign ratio_ok = min_scl < max_scl;
	assign neg_scl  = RW'(neg_seq_current) * RW'(PCT_FULL);
	assign pos_scl  = RW'(pos_seq_current) * RW'(sq_ratio);
	assign seq_ok   = neg_scl > pos_scl;

	// ******************************
	// Summation check
	// ******************************
	logic signed [SUM_W-1:0] res_smp;
	logic signed [SUM_W-1:0] sum_smp;
	logic        [SUM_W-1:0] sum_abs;
	logic                    sum_hit;

	always_comb
	begin
		res_smp = '0;
		if (rmon_ff)
		begin
			unique case (rsel_ff)
				RSEL_ONE: res_smp = SUM_W'(residual_input_one);
				RSEL_TWO: res_smp = SUM_W'(residual_input_two);
				default:  res_smp = '0;
			endcase
		end
	end

	assign sum_smp = SUM_W'(phase_a_sample) + SUM_W'(phase_b_sample)
		+ SUM_W'(phase_c_sample) + (rsub_ff ? -res_smp : res_smp);
	assign sum_abs = sum_smp[SUM_W-1] ? SUM_W'(-sum_smp) : SUM_W'(sum_smp);

	cts_hyst_cmp #(.W(SUM_W)) u_sum (
		.clk    (clk),
		.nrst   (nrst),
		.mag    (sum_abs),
		.thr    (SUM_W'(sum_lim)),
		.under  (1'b0),
		.hit_ff (sum_hit)
	);

	// ******************************
	// Combined condition
	// ******************************
	logic cond;

	// Compared every cycle, not only on upstream refresh
	assign cond = !(|over_hi) && (|over_lo) && (|under_lo)
		&& ratio_ok && seq_ok && (!sum_en_ff || sum_hit);

	// ******************************
	// Millisecond base
	// ******************************
	logic tick;

	assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			tick_cnt_ff <= '0;
		else if (tick)
			tick_cnt_ff <= '0;
		else
			tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			time_ms_ff <= '0;
		else if (tick)
			time_ms_ff <= time_ms_ff + TS_W'(1);
	end

	// ******************************
	// Alarm delay and outputs
	// ******************************
	logic nxt_alarm;
	logic nxt_blocked;

	// Delay counts whole ms ticks: up to 1 ms early on the first tick
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			dly_cnt_ff <= '0;
		else if (!cond || block_in)
			dly_cnt_ff <= '0;
		else if (tick && dly_cnt_ff < dly_ms)
			dly_cnt_ff <= dly_cnt_ff + FLD_W'(1);
	end

	assign nxt_blocked = block_in;
	assign nxt_alarm   = cond && !block_in && (dly_cnt_ff >= dly_ms);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			alarm_ff   <= 1'b0;
			blocked_ff <= 1'b0;
		end
		else
		begin
			alarm_ff   <= nxt_alarm;
			blocked_ff <= nxt_blocked;
		end
	end

	assign alarm_out   = alarm_ff;
	assign blocked_out = blocked_ff;

	// ******************************
	// Events
	// ******************************
	// Flags: [0] blocked on, [1] blocked off, [2] alarm on, [3] alarm off
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			evt_valid_ff <= 1'b0;
			evt_flags_ff <= '0;
			evt_time_ff  <= '0;
		end
		else
		begin
			evt_valid_ff <= (nxt_alarm != alarm_ff) || (nxt_blocked != blocked_ff);
			evt_flags_ff <= {alarm_ff && !nxt_alarm, !alarm_ff && nxt_alarm,
				blocked_ff && !nxt_blocked, !blocked_ff && nxt_blocked};
			evt_time_ff  <= time_ms_ff;
		end
	end

	assign evt_valid   = evt_valid_ff;
	assign evt_flags   = evt_flags_ff;
	assign evt_time_ms = evt_time_ff;

	// ******************************
	// Event counters
	// ******************************
	// A new event in the clearing cycle counts as one, not lost
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			alm_cnt_ff <= '0;
		else if (nxt_alarm && !alarm_ff)
			alm_cnt_ff <= clr_alm ? CNT_W'(1) : alm_cnt_ff + CNT_W'(1);
		else if (clr_alm)
			alm_cnt_ff <= '0;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			blk_cnt_ff <= '0;
		else if (nxt_blocked && !blocked_ff)
			blk_cnt_ff <= clr_blk ? CNT_W'(1) : blk_cnt_ff + CNT_W'(1);
		else if (clr_blk)
			blk_cnt_ff <= '0;
	end

	// ******************************
	// Register writes
	// ******************************
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rsel_ff   <= RSEL_NONE;
			rsub_ff   <= 1'b0;
			sum_en_ff <= 1'b0;
			rmon_ff   <= 1'b0;
		end
		else if (wr_acc && paddr == A_CTRL)
		begin
			rsel_ff   <= pwdata[C_RSEL +: 2];
			rsub_ff   <= pwdata[C_RSUB];
			sum_en_ff <= pwdata[C_SUM];
			rmon_ff   <= pwdata[C_RMON];
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int g = 0; g < NGRP; g++)
				for (int f = 0; f < NFLD; f++)
					par_ff[g][f] <= f_par_rst(3'(f));
		end
		else if (wr_acc && grp_hit)
			par_ff[a_grp][a_fld] <= pwdata[FLD_W-1:0];
	end

	// ******************************
	// Register reads
	// ******************************
	// Read data captured in setup so access completes with no wait state
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			prdata_ff  <= '0;
			pslverr_ff <= 1'b0;
		end
		else if (setup)
		begin
			pslverr_ff <= !(gen_hit || grp_hit);
			prdata_ff  <= '0;
			if (grp_hit)
				prdata_ff <= DATA_W'(par_ff[a_grp][a_fld]);
			else if (paddr == A_CTRL)
				prdata_ff <= DATA_W'({rmon_ff, sum_en_ff, rsub_ff, rsel_ff});
			else if (paddr == A_STATUS)
				prdata_ff <= DATA_W'({grp_sel, cond, blocked_ff, alarm_ff});
			else if (paddr == A_ALM_CNT)
				prdata_ff <= alm_cnt_ff;
			else if (paddr == A_BLK_CNT)
				prdata_ff <= blk_cnt_ff;
			else if (paddr == A_TIME)
				prdata_ff <= time_ms_ff;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = (psel && penable && !pwrite) ? prdata_ff : '0;
	assign pslverr = psel && penable && pslverr_ff;

endmodule // cts_supervision

// File: sim/cts_supervision_asserts.sv
// Concurrent checks on the ports of the CT supervision top module.
// Assumes one clock domain with nrst asynchronous and active low.
`timescale 1ns/1ps

module cts_supervision_asserts
	import cts_pkg::*;
(
	input wire logic              clk,
	input wire logic              nrst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic [CUR_W-1:0]  phase_a_current,
	input wire logic [CUR_W-1:0]  phase_b_current,
	input wire logic [CUR_W-1:0]  phase_c_current,
	input wire logic [CUR_W-1:0]  neg_seq_current,
	input wire logic              block_in,
	input wire logic              alarm_out,
	input wire logic              blocked_out,
	input wire logic              evt_valid,
	input wire logic [3:0]        evt_flags
);
	// ******************************
	// Properties
	// ******************************
	// Equal phases cannot pass the min/max ratio test while the ratio setting is 100 or less
	wire unequal = (phase_a_current != phase_b_current) || (phase_b_current != phase_c_current);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_out_edge;
		$changed(alarm_out) || $changed(blocked_out);
	endsequence
	sequence s_evt_code;
		evt_flags == {$fell(alarm_out), $rose(alarm_out), $fell(blocked_out), $rose(blocked_out)};
	endsequence
	sequence s_held_off;
		blocked_out && !alarm_out;
	endsequence

	AST_BLK_FORCE: assert property (block_in |=> s_held_off)
		else $error("block input did not force blocked on and alarm off");
	AST_BLK_RELEASE: assert property (!block_in |=> !blocked_out)
		else $error("blocked output stayed on after block input fell");
	AST_EVT_ON_EDGE: assert property (s_out_edge |-> evt_valid)
		else $error("output edge without an event");
	AST_EVT_CODE: assert property (evt_valid |-> s_evt_code)
		else $error("event flags do not match output edges");
	AST_RATIO_SEEN: assert property (alarm_out |-> $past(unequal) || $past(unequal, 2))
		else $error("alarm with equal phase magnitudes");
	AST_SEQ_SEEN: assert property (alarm_out |-> $past(neg_seq_current) != 0
		|| $past(neg_seq_current, 2) != 0)
		else $error("alarm with zero negative sequence current");
	AST_ERR_ACCESS: assert property (pslverr |-> psel && penable)
		else $error("slave error outside an access phase");
	AST_RD_IDLE: assert property (!(psel && penable && !pwrite) |-> prdata == '0)
		else $error("read data not zero outside a read access");
	AST_READY: assert property (pready)
		else $error("ready low");
endmodule // cts_supervision_asserts

bind cts_supervision cts_supervision_asserts u_cts_supervision_asserts (
	.clk, .nrst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
	.phase_a_current, .phase_b_current, .phase_c_current, .neg_seq_current,
	.block_in, .alarm_out, .blocked_out, .evt_valid, .evt_flags
);

// File: sim/cts_meas_model.sv
// Upstream measurement stage: magnitudes and sequence currents.
// Assumes the bench sets targets freely; they reach the block on the update base only.
`timescale 1ns/1ps

module cts_meas_model
	import cts_pkg::*;
#(
	parameter int UPD_CYC = 50
)(
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [CUR_W-1:0] tgt_a,
	input  wire logic [CUR_W-1:0] tgt_b,
	input  wire logic [CUR_W-1:0] tgt_c,
	input  wire logic [CUR_W-1:0] tgt_pos,
	input  wire logic [CUR_W-1:0] tgt_neg,
	output logic      [CUR_W-1:0] phase_a_current,
	output logic      [CUR_W-1:0] phase_b_current,
	output logic      [CUR_W-1:0] phase_c_current,
	output logic      [CUR_W-1:0] pos_seq_current,
	output logic      [CUR_W-1:0] neg_seq_current
);
	int tick_ff;

	// Values move only on the update base, never in between
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tick_ff <= 0;
			{phase_a_current, phase_b_current, phase_c_current} <= '0;
			{pos_seq_current, neg_seq_current} <= '0;
		end
		else if (tick_ff == UPD_CYC - 1)
		begin
			tick_ff <= 0;
			{phase_a_current, phase_b_current, phase_c_current} <= {tgt_a, tgt_b, tgt_c};
			{pos_seq_current, neg_seq_current} <= {tgt_pos, tgt_neg};
		end
		else
			tick_ff <= tick_ff + 1;
	end
endmodule // cts_meas_model

// File: sim/cts_supervision_tb.sv
// Self-checking bench for the CT supervision block.
// Assumes the checker binds itself; the millisecond tick is cut to 10 cycles.
`timescale 1ns/1ps

`define CHK(NM, EXP, GOT) \
	begin \
		checks_done++; \
		if ((GOT) !== (EXP)) \
		begin \
			mismatches++; \
			$display("CHECK FAILED %s exp %0h got %0h", NM, EXP, GOT); \
		end \
	end

module cts_supervision_tb;
	import cts_pkg::*;

	localparam int TCK = 10;

	logic                    clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0]       paddr;
	logic [DATA_W-1:0]       pwdata, prdata;
	logic [CUR_W-1:0]        phase_a_current, phase_b_current, phase_c_current;
	logic [CUR_W-1:0]        pos_seq_current, neg_seq_current;
	logic [CUR_W-1:0]        tgt_a, tgt_b, tgt_c, tgt_pos, tgt_neg;
	logic signed [SMP_W-1:0] res_one, res_two;
	logic                    block_in, alarm_out, blocked_out, evt_valid;
	logic [2:0]              grp_sel;
	logic [3:0]              evt_flags;
	logic [TS_W-1:0]         evt_time_ms;
	int                      mismatches, checks_done, cyc;

	cts_meas_model #(.UPD_CYC(5 * TCK)) u_cts_meas_model (
		.clk, .nrst, .tgt_a, .tgt_b, .tgt_c, .tgt_pos, .tgt_neg,
		.phase_a_current, .phase_b_current, .phase_c_current,
		.pos_seq_current, .neg_seq_current);

	// Samples follow the magnitudes so the summation sees a known total
	cts_supervision #(.TICK_CYCLES(TCK)) u_cts_supervision (
		.clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .phase_a_current, .phase_b_current, .phase_c_current,
		.phase_a_sample(signed'(phase_a_current)), .phase_b_sample(signed'(phase_b_current)),
		.phase_c_sample(signed'(phase_c_current)), .residual_input_one(res_one),
		.residual_input_two(res_two), .pos_seq_current, .neg_seq_current, .block_in,
		.grp_sel, .alarm_out, .blocked_out, .evt_valid, .evt_flags, .evt_time_ms);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) cyc <= nrst ? cyc + 1 : 0;

	// ******************************
	// Bus and stimulus tasks
	// ******************************
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] q, output logic e);
		int n;
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
		@(posedge clk);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] q;
		logic              e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string nm);
		logic [DATA_W-1:0] q;
		logic              e;
		apb(1'b0, a, '0, q, e);
		`CHK(nm, exp, q)
	endtask
	function automatic logic [ADDR_W-1:0] ga(input int g, input int f);
		return {1'b1, g[2:0], f[2:0], 2'b00};
	endfunction
	task automatic time_alarm(output int n);
		int w;
		w = 0;
		// Let freshly written targets land before comparing
		@(posedge clk);
		while (phase_c_current !== tgt_c && w < 100)
		begin
			@(posedge clk);
			w++;
		end
		n = 0;
		while (alarm_out !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic step(input logic [CUR_W-1:0] a, b, c, n, input logic exp, input bit hold,
		input string nm);
		int k;
		{tgt_a, tgt_b, tgt_c, tgt_pos, tgt_neg} <= {a, b, c, 16'h003c, n};
		k = 0;
		// A hold row must prove the alarm keeps its state past a full update
		if (hold)
			repeat (150) @(posedge clk);
		while (alarm_out !== exp && k < 400)
		begin
			@(posedge clk);
			k++;
		end
		`CHK(nm, exp, alarm_out)
	endtask
	task automatic fault();
		step(16'h0064, 16'h0064, 16'h0005, 16'h0028, 1'b1, 0, "fault");
	endtask

	// ******************************
	// Scenarios
	// ******************************
	task automatic t_regs();
		logic [FLD_W-1:0]  dflt [NFLD];
		logic [DATA_W-1:0] q;
		logic              e;
		dflt = '{D_HI, D_LO, D_RATIO, D_SEQ, D_SUM, D_DLY};
		rd(A_CTRL, '0, "ctrl_reset");
		for (int g = 0; g < NGRP; g++)
			for (int f = 0; f < NFLD; f++)
				rd(ga(g, f), {16'h0000, dflt[f]}, "group_default");
		wr(ga(7, F_SUM), 32'h0000_0033);
		rd(ga(7, F_SUM), 32'h0000_0033, "group_write");
		rd(ga(6, F_SUM), {16'h0000, D_SUM}, "group_apart");
		apb(1'b0, 9'h018, '0, q, e);
		`CHK("unmapped_err", 1'b1, e)
		`CHK("unmapped_data", 32'h0000_0000, q)
	endtask
	task automatic t_delay();
		int n;
		wr(ga(0, F_DLY), 32'h0000_0002);
		{tgt_a, tgt_b, tgt_c, tgt_pos, tgt_neg} <= {16'h0064, 16'h0064, 16'h0005, 16'h003c, 16'h0028};
		time_alarm(n);
		`CHK("alarm_delay", 1'b1, n >= 8 && n <= 26)
		`CHK("alarm_on_evt", 5'h14, {evt_valid, evt_flags})
		`CHK("evt_stamp", 1'b1, evt_time_ms + 1 >= cyc / TCK && evt_time_ms <= cyc / TCK + 1)
		rd(A_ALM_CNT, 32'h0000_0001, "alarm_count");
	endtask
	task automatic t_block();
		int n;
		wr(A_CNT_CLR, 32'h0000_0003);
		rd(A_ALM_CNT, '0, "alarm_count_clr");
		block_in <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK("block_on", 7'h59, {blocked_out, alarm_out, evt_valid, evt_flags})
		rd(A_BLK_CNT, 32'h0000_0001, "blocked_count");
		repeat (60) @(posedge clk);
		`CHK("block_hold", 2'b10, {blocked_out, alarm_out})
		block_in <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("block_off", 6'h12, {blocked_out, evt_valid, evt_flags})
		time_alarm(n);
		`CHK("delay_restart", 1'b1, n >= 8 && n <= 26)
	endtask
	task automatic t_cond();
		step(16'h0082, 16'h0064, 16'h0005, 16'h0028, 1'b0, 0, "over_high");
		step(16'h0076, 16'h0064, 16'h0005, 16'h0028, 1'b0, 1, "over_hold");
		fault();
		step(16'h0064, 16'h0064, 16'h000a, 16'h0028, 1'b1, 1, "under_hold");
		step(16'h0064, 16'h0064, 16'h000b, 16'h0028, 1'b0, 0, "under_gone");
		fault();
		step(16'h0064, 16'h0064, 16'h0005, 16'h0014, 1'b0, 0, "seq_low");
		fault();
		step(16'h0008, 16'h0009, 16'h0005, 16'h0028, 1'b0, 0, "none_above");
		fault();
		step(16'h000f, 16'h000f, 16'h0008, 16'h0028, 1'b0, 0, "ratio_high");
		fault();
	endtask
	task automatic t_group();
		wr(ga(1, F_HI), 32'h0000_0032);
		grp_sel <= 3'h1;
		step(16'h0064, 16'h0064, 16'h0005, 16'h0028, 1'b0, 0, "group_one");
		rd(A_STATUS, 32'h0000_0008, "status_group");
		grp_sel <= 3'h0;
		fault();
	endtask
	task automatic t_sum();
		logic [DATA_W-1:0] modes [4];
		modes = '{32'h0000_001d, 32'h0000_0009, 32'h0000_001a, 32'h0000_0018};
		res_one <= 16'hff33;
		res_two <= 16'h0000;
		for (int i = 0; i < 4; i++)
		begin
			wr(A_CTRL, 32'h0000_0019);
			fault_sum(1'b0);
			wr(A_CTRL, modes[i]);
			fault_sum(1'b1);
		end
		wr(A_CTRL, 32'h0000_0000);
	endtask
	task automatic fault_sum(input logic exp);
		step(16'h0064, 16'h0064, 16'h0005, 16'h0028, exp, 0, "sum_mode");
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		{tgt_a, tgt_b, tgt_c, tgt_pos, tgt_neg} = '0;
		{res_one, res_two, block_in, grp_sel} = '0;
		{mismatches, checks_done, cyc} = '0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_regs();
		t_delay();
		t_block();
		t_cond();
		t_group();
		t_sum();
		wrap_up();
	end

	initial
	begin
		#(4 * 60000);
		mismatches++;
		wrap_up();
	end
endmodule // cts_supervision_tb
